// File: hdl/rcl_slip.sv
// slip counter of the manual word aligner
// assumes one-cycle slip requests on pclk
`timescale 1ns/100ps
`default_nettype none
`include "rcl_map.svh"

module rcl_slip (
  input wire logic pclk,
  input wire logic presetn,
  rcl_slip_if.slip sif
);

  logic [3:0] next_count;

  // ==========================================================
  // slip count
  // count is cleared outside manual mode and wraps from 9 back to 0 on the next slip
  always_comb begin
    next_count = sif.count;
    if (!sif.manual) begin
      next_count = 4'h0;
    end else if (sif.slip_req) begin
      next_count = (sif.count == `RCL_SLIP_MAX) ? 4'h0 : sif.count + 4'h1;
    end
  end

  // held between slips, four bits unsigned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.count <= 4'h0;
    end else begin
      sif.count <= next_count;
    end
  end

endmodule

`default_nettype wire

// File: hdl/rcl_top.sv
// receiver lock, signal detect, slip and fifo status for one serial channel
// assumes an apb master on pclk; lock-mode pins and serial input are asynchronous
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rcl_map.svh"

module rcl_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        force_lock_to_data,
  input  wire logic        force_lock_to_ref,
  input  wire logic        serial_in,
  input  wire logic        fifo_rd_en,
  output logic             locked_to_data,
  output logic             signal_detect,
  output logic             pipe_elec_idle,
  output logic             fifo_error,
  output logic      [3:0]  slip_count_out,
  output logic             fifo_rd_clk,
  output logic             recovered_clk
);

  rcl_slip_if sif ();

  rcl_slip u_slip (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif.slip)
  );

  // ==========================================================
  // helpers
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `RCL_OFF_CTRL) || (a == `RCL_OFF_THRESH) ||
              (a == `RCL_OFF_STATUS) || (a == `RCL_OFF_SLIP);
  endfunction

  // ==========================================================
  // input synchronisers
  logic [2:0] meta;
  logic [2:0] sync;
  logic       ser_prev;
  logic       ltd_s;
  logic       ltr_s;
  logic       ser_s;

  // first stage feeds only the second; edge compare uses stage two onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= 3'h0;
      sync     <= 3'h0;
      ser_prev <= 1'b0;
    end else begin
      meta     <= {force_lock_to_data, force_lock_to_ref, serial_in};
      sync     <= meta;
      ser_prev <= sync[0];
    end
  end

  assign ltd_s = sync[2];
  assign ltr_s = sync[1];
  assign ser_s = sync[0];

  // ==========================================================
  // apb slave
  logic [4:0]  ctrl;
  logic [7:0]  thresh;
  logic [4:0]  next_ctrl;
  logic [7:0]  next_thresh;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_slip_req;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [1:0]  sel_code;
  logic        fifo_full;
  logic        fifo_empty;
  rcl_pkg::rcl_mode_t mode;

  assign mode = rcl_pkg::rcl_mode_t'(ctrl[`RCL_CTRL_MODE_MSB:`RCL_CTRL_MODE_LSB]);

  // read mux; unmapped offsets read zero
  always_comb begin
    status_word                                    = 32'h0;
    status_word[`RCL_ST_LTD]                       = locked_to_data;
    status_word[`RCL_ST_SIGDET]                    = signal_detect;
    status_word[`RCL_ST_FIFO_ERR]                  = fifo_error;
    status_word[`RCL_ST_EIDLE]                     = pipe_elec_idle;
    status_word[`RCL_ST_FULL]                      = fifo_full;
    status_word[`RCL_ST_EMPTY]                     = fifo_empty;
    status_word[`RCL_ST_SEL_MSB:`RCL_ST_SEL_LSB]   = sel_code;
    case (paddr)
      `RCL_OFF_CTRL:   rd_word = {27'h0, ctrl};
      `RCL_OFF_THRESH: rd_word = {24'h0, thresh};
      `RCL_OFF_STATUS: rd_word = status_word;
      `RCL_OFF_SLIP:   rd_word = {28'h0, sif.count};
      default:         rd_word = 32'h0;
    endcase
  end

  // pready rises as the access phase starts; read data is captured in setup, write data in access
  always_comb begin
    next_ctrl     = ctrl;
    next_thresh   = thresh;
    next_prdata   = prdata;
    next_pready   = 1'b0;
    next_pslverr  = 1'b0;
    next_slip_req = 1'b0;
    if (psel && !penable) begin
      next_pready  = 1'b1;
      next_prdata  = pwrite ? 32'h0 : rd_word;
      next_pslverr = !reg_hit(paddr);
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        `RCL_OFF_CTRL:   next_ctrl   = pwdata[4:0];
        `RCL_OFF_THRESH: next_thresh = pwdata[7:0];
        `RCL_OFF_SLIP:   next_slip_req = pwdata[0] & ctrl[`RCL_CTRL_MAN_ALIGN];
        default:         next_ctrl   = ctrl;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl         <= `RCL_CTRL_RESET;
      thresh       <= `RCL_THRESH_RESET;
      prdata       <= 32'h0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      sif.slip_req <= 1'b0;
    end else begin
      ctrl         <= next_ctrl;
      thresh       <= next_thresh;
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
      sif.slip_req <= next_slip_req;
    end
  end

  assign sif.manual     = ctrl[`RCL_CTRL_MAN_ALIGN];
  assign slip_count_out = sif.count;

  // ==========================================================
  // signal level detection: edges per window stand in for amplitude
  logic [9:0] win_cnt;
  logic [7:0] edge_cnt;
  logic       level_hi;
  logic       idle_inf;
  logic [9:0] next_win_cnt;
  logic [7:0] next_edge_cnt;
  logic       next_level_hi;
  logic       next_idle_inf;
  logic       next_signal_detect;
  logic       next_pipe_elec_idle;
  logic       sigdet_mode_ok;

  assign sigdet_mode_ok = (mode == rcl_pkg::RCL_MODE_BASIC_8B10B) || (mode == rcl_pkg::RCL_MODE_PIPE);

  always_comb begin
    next_win_cnt  = win_cnt + 10'h001;
    next_edge_cnt = edge_cnt;
    next_level_hi = level_hi;
    next_idle_inf = idle_inf;
    if ((ser_s != ser_prev) && (edge_cnt != 8'hFF)) begin
      next_edge_cnt = edge_cnt + 8'h01; // saturates rather than wrapping
    end
    if (win_cnt == 10'(`RCL_WIN_CYC - 1)) begin
      next_win_cnt  = 10'h000;
      next_edge_cnt = 8'h00;
      next_level_hi = (edge_cnt > thresh);
      next_idle_inf = (edge_cnt == 8'h00);
    end
    next_signal_detect  = next_level_hi & sigdet_mode_ok;
    next_pipe_elec_idle = ctrl[`RCL_CTRL_EI_INFER] ? next_idle_inf : !next_signal_detect;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt        <= 10'h000;
      edge_cnt       <= 8'h00;
      level_hi       <= 1'b0;
      idle_inf       <= 1'b1;
      signal_detect  <= 1'b0;
      pipe_elec_idle <= 1'b1;
    end else begin
      win_cnt        <= next_win_cnt;
      edge_cnt       <= next_edge_cnt;
      level_hi       <= next_level_hi;
      idle_inf       <= next_idle_inf;
      signal_detect  <= next_signal_detect;
      pipe_elec_idle <= next_pipe_elec_idle;
    end
  end

  // ==========================================================
  // clock recovery lock state
  rcl_pkg::rcl_cdr_t cdr;
  rcl_pkg::rcl_cdr_t next_cdr;
  rcl_pkg::rcl_sel_t sel;
  logic [10:0]       lock_cnt;
  logic [10:0]       next_lock_cnt;

  // data bit takes priority, so 1x means data regardless of the ref bit
  always_comb begin
    casez ({ltd_s, ltr_s})
      2'b1?:   sel = rcl_pkg::RCL_SEL_MAN_DATA;
      2'b01:   sel = rcl_pkg::RCL_SEL_MAN_REF;
      default: sel = rcl_pkg::RCL_SEL_AUTO;
    endcase
  end

  assign sel_code = sel;

  // auto mode needs signal held for the lock time before leaving reference
  always_comb begin
    next_cdr      = cdr;
    next_lock_cnt = 11'h000;
    case (sel)
      rcl_pkg::RCL_SEL_MAN_DATA: next_cdr = rcl_pkg::RCL_CDR_DATA;
      rcl_pkg::RCL_SEL_MAN_REF:  next_cdr = rcl_pkg::RCL_CDR_REF;
      rcl_pkg::RCL_SEL_AUTO: begin
        if (!level_hi) begin
          next_cdr = rcl_pkg::RCL_CDR_REF;
        end else if (cdr == rcl_pkg::RCL_CDR_REF) begin
          next_lock_cnt = lock_cnt + 11'h001;
          if (lock_cnt == 11'(`RCL_LOCK_CYC - 1)) begin
            next_cdr      = rcl_pkg::RCL_CDR_DATA;
            next_lock_cnt = 11'h000;
          end
        end
      end
      default: next_cdr = rcl_pkg::RCL_CDR_REF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdr            <= rcl_pkg::RCL_CDR_REF;
      lock_cnt       <= 11'h000;
      locked_to_data <= 1'b0;
    end else begin
      cdr            <= next_cdr;
      lock_cnt       <= next_lock_cnt;
      locked_to_data <= (next_cdr == rcl_pkg::RCL_CDR_DATA);
    end
  end

  // ==========================================================
  // phase-compensation fifo occupancy; words arrive only while locked to data
  logic [3:0] word_cnt;
  logic [3:0] fill;
  logic [3:0] next_word_cnt;
  logic [3:0] next_fill;
  logic       wr_ok;
  logic       rd_ok;

  assign fifo_full  = (fill == `RCL_FIFO_DEPTH);
  assign fifo_empty = (fill == 4'h0);

  always_comb begin
    next_word_cnt = (word_cnt == 4'(`RCL_WORD_CYC - 1)) ? 4'h0 : word_cnt + 4'h1;
    wr_ok         = (word_cnt == 4'h0) && (cdr == rcl_pkg::RCL_CDR_DATA) && !fifo_full;
    rd_ok         = fifo_rd_en && !fifo_empty;
    next_fill     = fill;
    if (wr_ok && !rd_ok) begin
      next_fill = fill + 4'h1;
    end else if (rd_ok && !wr_ok) begin
      next_fill = fill - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_cnt   <= 4'h0;
      fill       <= 4'h0;
      fifo_error <= 1'b1;
    end else begin
      word_cnt   <= next_word_cnt;
      fill       <= next_fill;
      fifo_error <= (next_fill == `RCL_FIFO_DEPTH) || (next_fill == 4'h0);
    end
  end

  // ==========================================================
  // clock outputs, divided from pclk so nothing here is a second domain
  logic [2:0] rec_cnt;
  logic [2:0] next_rec_cnt;
  logic       next_rec_clk;
  logic       next_core_clk;

  always_comb begin
    next_rec_cnt = rec_cnt;
    next_rec_clk = 1'b0;
    if ((mode == rcl_pkg::RCL_MODE_GIGABIT_ETHERNET_MODE) && (cdr == rcl_pkg::RCL_CDR_DATA)) begin
      next_rec_cnt = (rec_cnt == 3'(`RCL_REC_HALF_CYC - 1)) ? 3'h0 : rec_cnt + 3'h1;
      next_rec_clk = (rec_cnt == 3'(`RCL_REC_HALF_CYC - 1)) ? !recovered_clk : recovered_clk;
    end else begin
      next_rec_cnt = 3'h0;
    end
    next_core_clk = ctrl[`RCL_CTRL_CORE_EN] ? !fifo_rd_clk : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt       <= 3'h0;
      recovered_clk <= 1'b0;
      fifo_rd_clk   <= 1'b0;
    end else begin
      rec_cnt       <= next_rec_cnt;
      recovered_clk <= next_rec_clk;
      fifo_rd_clk   <= next_core_clk;
    end
  end

endmodule

`default_nettype wire

// File: shared/rcl_map.svh
// register offsets, field positions, reset values and timing counts of the rx lock/status block
// assumes a 100 MHz pclk and an 8-bit apb byte address
//
// Functional notes
// - optional clock output reads phase-compensation fifo
// - fifo error high when full or empty
// - manual alignment reports slipped bits, 0 to 9
// - lock output high locked-to-data, low reference
// - force-to-data high wins over force-to-reference
// - pair decodes auto, manual reference, manual data
// - signal detect only basic-8b10b or pipe mode
// - recovered slow clock only in gigabit ethernet
// - electrical idle is inverted signal detect (with RCL_CTRL_EI_INFER set it follows a window with zero edges instead)
`ifndef RCL_MAP_SVH
`define RCL_MAP_SVH

// ==========================================================
// register offsets
`define RCL_OFF_CTRL       8'h00
`define RCL_OFF_THRESH     8'h04
`define RCL_OFF_STATUS     8'h08
`define RCL_OFF_SLIP       8'h0C

// ==========================================================
// control fields
`define RCL_CTRL_MODE_LSB  0
`define RCL_CTRL_MODE_MSB  1
`define RCL_CTRL_MAN_ALIGN 2
`define RCL_CTRL_CORE_EN   3
`define RCL_CTRL_EI_INFER  4
`define RCL_CTRL_RESET     5'h00
`define RCL_THRESH_RESET   8'h04

// ==========================================================
// status fields
`define RCL_ST_LTD         0
`define RCL_ST_SIGDET      1
`define RCL_ST_FIFO_ERR    2
`define RCL_ST_EIDLE       3
`define RCL_ST_FULL        4
`define RCL_ST_EMPTY       5
`define RCL_ST_SEL_LSB     6
`define RCL_ST_SEL_MSB     7

// ==========================================================
// slip counter and fifo model
`define RCL_SLIP_MAX       4'h9
`define RCL_FIFO_DEPTH     4'h8

// ==========================================================
// timing
`define RCL_CLK_NS         10
`define RCL_WIN_NS         1000
`define RCL_WIN_CYC        ((`RCL_WIN_NS + `RCL_CLK_NS - 1) / `RCL_CLK_NS)
`define RCL_LOCK_NS        2000
`define RCL_LOCK_CYC       ((`RCL_LOCK_NS + `RCL_CLK_NS - 1) / `RCL_CLK_NS)
`define RCL_WORD_CYC       10
`define RCL_REC_HALF_CYC   5

`endif

// File: shared/rcl_pkg.sv
// types shared by the rx lock/status block
// assumes rcl_map.svh holds all numbers
`default_nettype none

package rcl_pkg;

  // channel protocol mode in the control register
  typedef enum logic [1:0] {
    RCL_MODE_BASIC,
    RCL_MODE_BASIC_8B10B,
    RCL_MODE_PIPE,
    RCL_MODE_GIGABIT_ETHERNET_MODE
  } rcl_mode_t;

  // clock recovery lock state
  typedef enum logic {
    RCL_CDR_REF,
    RCL_CDR_DATA
  } rcl_cdr_t;

  // decoded lock selection
  typedef enum logic [1:0] {
    RCL_SEL_AUTO,
    RCL_SEL_MAN_REF,
    RCL_SEL_MAN_DATA
  } rcl_sel_t;

endpackage

`default_nettype wire

// File: shared/rcl_slip_if.sv
// carrier between the main block and the slip counter
// assumes both ends run on pclk
`timescale 1ns/100ps
`default_nettype none

interface rcl_slip_if;
  logic       slip_req;
  logic       manual;
  logic [3:0] count;

  modport ctrl (output slip_req, output manual, input count);
  modport slip (input slip_req, input manual, output count);
endinterface

`default_nettype wire

// File: verif/rcl_fabric.sv
// fabric-side user logic: serial traffic source and lock status synchronizer
// assumes pclk is the fabric clock
`timescale 1ns/100ps
`default_nettype none

module rcl_fabric (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic locked_to_data,
  output logic      serial_in,
  output logic      lock_sync
);
  logic s1;

  // ==========================================================
  // toggle every cycle while traffic runs; the idle line rests low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_in <= 1'b0;
    end else begin
      serial_in <= run ? !serial_in : 1'b0;
    end
  end

  // two flops before the lock status is used here, avoiding metastability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lock_sync, s1} <= 2'b00;
    end else begin
      {lock_sync, s1} <= {s1, locked_to_data};
    end
  end
endmodule

`default_nettype wire

// File: verif/rcl_monitor.sv
// assertion checker for the rx lock/status block
// assumes it is bound to rcl_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "rcl_map.svh"

module rcl_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       force_lock_to_data,
  input wire logic       force_lock_to_ref,
  input wire logic       locked_to_data,
  input wire logic       signal_detect,
  input wire logic       pipe_elec_idle,
  input wire logic [3:0] slip_count_out,
  input wire logic       fifo_rd_clk,
  input wire logic       recovered_clk
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // named steps
  sequence setup_s; psel && !penable; endsequence
  sequence hold_data_s; force_lock_to_data [*4]; endsequence
  sequence hold_ref_s; (!force_lock_to_data && force_lock_to_ref) [*4]; endsequence

  // ==========================================================
  // lock pins: four cycles covers the two-flop path plus output flop
  lock_data_a: assert property (hold_data_s |=> locked_to_data)
    else $error("lock to data not reached");
  lock_ref_a: assert property (hold_ref_s |=> !locked_to_data)
    else $error("lock to reference not reached");
  // bus answer: no wait states, one-cycle response
  pready_resp_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_map_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
    else $error("error response wrong for address");
  // slip count stays in range and only steps by one or restarts
  slip_range_a: assert property (slip_count_out <= `RCL_SLIP_MAX)
    else $error("slip count out of range");
  slip_step_a: assert property ($changed(slip_count_out) |->
    (slip_count_out == $past(slip_count_out) + 4'h1 || slip_count_out == 4'h0))
    else $error("slip count jumped");
  sigdet_eidle_a: assert property (signal_detect |-> !pipe_elec_idle)
    else $error("idle shown while signal present");
  rdclk_tgl_a: assert property (fifo_rd_clk |=> !fifo_rd_clk)
    else $error("fifo read clock stuck high");
  recclk_half_a: assert property ($rose(recovered_clk) |=> recovered_clk [*4] ##1 !recovered_clk)
    else $error("recovered clock half period wrong");
endmodule

bind rcl_top rcl_monitor i_mon (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .force_lock_to_data, .force_lock_to_ref, .locked_to_data, .signal_detect, .pipe_elec_idle,
  .slip_count_out, .fifo_rd_clk, .recovered_clk);

`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the rx lock/status block
// assumes rcl_top with an apb slave and the fabric model beside it
`timescale 1ns/100ps
`default_nettype none
`include "rcl_map.svh"

module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, fld = 1'b0, flr = 1'b0, run = 1'b0, rd_en = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata;
  logic [31:0] prdata;
  logic [3:0]  slip;
  logic        pready, pslverr, ltd, sd, eidle, ferr, rclk, rcv, ser, lsync;
  int          mismatches = 0, num_checks = 0, cyc = 0, n, rc, fc;

  rcl_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .force_lock_to_data(fld), .force_lock_to_ref(flr), .serial_in(ser), .fifo_rd_en(rd_en),
    .locked_to_data(ltd), .signal_detect(sd), .pipe_elec_idle(eidle), .fifo_error(ferr),
    .slip_count_out(slip), .fifo_rd_clk(rclk), .recovered_clk(rcv));
  rcl_fabric i_fab (.pclk(pclk), .presetn(presetn), .run(run), .locked_to_data(ltd),
    .serial_in(ser), .lock_sync(lsync));

  // ==========================================================
  // clock and hang guard
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      test_done();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // one apb transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle edge so a following call never drives psel twice in one step
  endtask
  task automatic cnt100();
    logic pr, pf;
    rc = 0;
    fc = 0;
    pr = rcv;
    pf = rclk;
    repeat (100) begin
      @(posedge pclk);
      rc += int'(rcv === 1'b1 && pr === 1'b0);
      fc += int'(rclk === 1'b1 && pf === 1'b0);
      pr = rcv;
      pf = rclk;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    cy(20);
    presetn <= 1'b1;
    cy(1);
    chk(ferr, 1);
    chk(ltd, 0);
    chk(eidle, 1);
    chk(slip, 0);
    xfer(0, `RCL_OFF_CTRL, 0); chk(rdata, 0);
    xfer(0, `RCL_OFF_THRESH, 0); chk(rdata, `RCL_THRESH_RESET);
    xfer(0, 8'h10, 0); chk(err, 1); chk(rdata, 0);
    // slips are ignored outside manual alignment, then count and wrap
    xfer(1, `RCL_OFF_SLIP, 1); cy(2); chk(slip, 0);
    xfer(1, `RCL_OFF_CTRL, 32'h4);
    for (n = 1; n <= 10; n++) begin
      xfer(1, `RCL_OFF_SLIP, 1); cy(2); chk(slip, n % 10);
    end
    xfer(0, `RCL_OFF_SLIP, 0); chk(rdata, 0);
    xfer(1, `RCL_OFF_CTRL, 0);
    // data force wins over reference force; fifo fills while locked
    fld <= 1'b1; flr <= 1'b1; cy(6); chk(ltd, 1);
    cy(3); chk(lsync, 1);
    cy(30); chk(ferr, 0);
    cy(100); chk(ferr, 1);
    fld <= 1'b0; cy(6); chk(ltd, 0);
    rd_en <= 1'b1; cy(2); chk(ferr, 0);
    cy(12); rd_en <= 1'b0; chk(ferr, 1);
    // threshold decides detection; auto lock follows the signal
    flr <= 1'b0;
    xfer(1, `RCL_OFF_THRESH, 32'hFF); xfer(0, `RCL_OFF_THRESH, 0); chk(rdata, 32'hFF);
    xfer(1, `RCL_OFF_CTRL, 32'h1); run <= 1'b1; cy(250); chk(sd, 0);
    xfer(1, `RCL_OFF_THRESH, 32'h4); cy(250); chk(sd, 1);
    chk(eidle, 0);
    cy(150); chk(ltd, 1);
    xfer(0, `RCL_OFF_STATUS, 0); chk(rdata & 32'h3, 32'h3);
    xfer(1, `RCL_OFF_CTRL, 0); cy(110); chk({sd, eidle}, 2'b01);
    // clocks: recovered only in gigabit ethernet, read clock with core enable
    xfer(1, `RCL_OFF_CTRL, 32'hB); cy(20); cnt100();
    chk(rc, 10);
    chk(fc, 50);
    chk(sd, 0);
    while (rcv !== 1'b1) @(posedge pclk);
    while (rcv !== 1'b0) @(posedge pclk);
    xfer(1, `RCL_OFF_CTRL, 32'h2); cy(110); cnt100();
    chk(rc, 0);
    chk(fc, 0);
    chk(sd, 1);
    // inferred idle follows traffic, not detection; losing the signal drops auto lock
    xfer(1, `RCL_OFF_CTRL, 32'h10); cy(110); chk({sd, eidle}, 2'b00);
    run <= 1'b0; cy(250); chk(eidle, 1);
    chk(ltd, 0);
    test_done();
  end
endmodule

`default_nettype wire
